/* File: hdl/acs_regs_pkg.sv */
package acs_regs_pkg;

  // ***************************************************************
  // Register offsets (byte addresses in configuration space)
  // ***************************************************************
  localparam logic [11:0] HOT_RESET_OFFSET = 12'h34c;
  localparam logic [11:0] CAP_HEADER_OFFSET = 12'h520;
  localparam logic [11:0] CAP_CTRL_OFFSET = 12'h524;
  localparam logic [11:0] EGRESS_VEC_OFFSET = 12'h528;

  // ***************************************************************
  // Field layout and fixed values
  // ***************************************************************
  localparam logic [15:0] EXT_CAP_ID = 16'h000d;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_PTR_RESET = 12'h270;
  localparam int NEXT_PTR_LSB = 20;
  localparam int VERSION_LSB = 16;
  localparam logic [6:0] CAP_SUPPORT = 7'h7f;
  localparam int VEC_SIZE_LSB = 8;
  localparam logic [7:0] EGRESS_VEC_SIZE = 8'h10;
  localparam int CTRL_LSB = 16;
  localparam int CTRL_BITS = 7;
  localparam int EGRESS_BITS = 16;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic HOT_RESET_BLOCK_RESET = 1'h0;
  localparam logic [6:0] CTRL_RESET = 7'h00;
  localparam logic [15:0] EGRESS_VEC_RESET = 16'h0000;

  // Preload targets for serial EEPROM / I2C loader
  typedef enum logic [1:0] {
    LOAD_HOT_RESET,
    LOAD_NEXT_PTR,
    LOAD_CTRL,
    LOAD_EGRESS
  } load_sel_t;

endpackage : acs_regs_pkg

/* File: hdl/cfg_access_if.sv */
`timescale 1ns/10ps
// Write strobe shared by configuration writes and serial preload
interface cfg_access_if;
  logic wrEn;
  logic [11:0] addr;
  logic [31:0] wrData;
  logic [3:0] byteEn;
  modport source (output wrEn, output addr, output wrData, output byteEn);
  modport sink (input wrEn, input addr, input wrData, input byteEn);
endinterface : cfg_access_if

/* File: hdl/cfg_write_merge.sv */
`timescale 1ns/10ps
// Picks between a configuration write and a preload write
module cfg_write_merge (
  // Configuration space write
  input wire logic cfgWrEn,
  input wire logic [11:0] cfgAddr,
  input wire logic [31:0] cfgWrData,
  input wire logic [3:0] cfgByteEn,
  // Preload write
  input wire logic loadEn,
  input wire acs_regs_pkg::load_sel_t loadSel,
  input wire logic [31:0] loadData,
  // Merged write
  cfg_access_if.source wr
);

  // ***************************************************************
  // Preload address map
  // ***************************************************************
  function automatic logic [11:0] loadAddr(input acs_regs_pkg::load_sel_t s);
    case (s)
      acs_regs_pkg::LOAD_HOT_RESET: loadAddr = acs_regs_pkg::HOT_RESET_OFFSET;
      acs_regs_pkg::LOAD_NEXT_PTR: loadAddr = acs_regs_pkg::CAP_HEADER_OFFSET;
      acs_regs_pkg::LOAD_CTRL: loadAddr = acs_regs_pkg::CAP_CTRL_OFFSET;
      default: loadAddr = acs_regs_pkg::EGRESS_VEC_OFFSET;
    endcase
  endfunction : loadAddr

  // Preload wins; the loader runs before software has access
  always_comb begin
    if (loadEn) begin
      wr.wrEn = 1'b1;
      wr.addr = loadAddr(loadSel);
      wr.wrData = loadData;
      wr.byteEn = 4'hf;
    end else begin
      wr.wrEn = cfgWrEn;
      wr.addr = cfgAddr;
      wr.wrData = cfgWrData;
      wr.byteEn = cfgByteEn;
    end
  end

endmodule : cfg_write_merge

/* File: hdl/switch_acs_hot_reset_regs.sv */
`timescale 1ns/10ps
// Summary of operation
// - Bit 0 at 34Ch blocks downstream hot reset
// - Hot reset register only in upstream port
// - Capability header only in downstream ports
// - Header bits 15:0 read 000Dh
// - Header bits 19:16 read version 1h
// - Next pointer default 270h, preloadable
// - Capability bits 6:0 read as one
// - Vector size field reads 10h
// - Bit 16 enables source validation
// - Bit 17 enables translation blocking
// - Bit 18 enables request redirection
// - Bit 19 enables completion redirection
// - Bit 20 enables upstream forwarding
// - Bit 21 enables egress control
// - Bit 22 enables direct translated peer-to-peer
// - Egress vector at 528h, reset zero
module switch_acs_hot_reset_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Port role: 1 for upstream port, 0 for downstream
  input wire logic isUpstream,
  // Configuration space access
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [11:0] cfgAddr,
  input wire logic [31:0] cfgWrData,
  input wire logic [3:0] cfgByteEn,
  output logic [31:0] cfgRdData,
  output logic cfgRdHit,
  // Serial EEPROM / I2C preload
  input wire logic loadEn,
  input wire acs_regs_pkg::load_sel_t loadSel,
  input wire logic [31:0] loadData,
  // Controls toward the datapath
  output logic downstreamHotResetBlock,
  output logic sourceValidEn,
  output logic transBlockEn,
  output logic reqRedirectEn,
  output logic cplRedirectEn,
  output logic upstreamFwdEn,
  output logic egressCtrlEn,
  output logic directTransEn,
  output logic [15:0] egressBlockVec
);

  cfg_access_if wr ();

  cfg_write_merge u_merge (
    .cfgWrEn(cfgWrEn),
    .cfgAddr(cfgAddr),
    .cfgWrData(cfgWrData),
    .cfgByteEn(cfgByteEn),
    .loadEn(loadEn),
    .loadSel(loadSel),
    .loadData(loadData),
    .wr(wr.source)
  );

  // ***************************************************************
  // Byte-enabled merge helper
  // ***************************************************************
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    mergeBytes = r;
  endfunction : mergeBytes

  // ***************************************************************
  // Storage
  // ***************************************************************
  logic hotResetBlock_reg;
  logic hotResetBlock_next;
  logic [11:0] nextPtr_reg;
  logic [11:0] nextPtr_next;
  logic [6:0] ctrl_reg;
  logic [6:0] ctrl_next;
  logic [15:0] egress_reg;
  logic [15:0] egress_next;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  logic rdHit_reg;
  logic rdHit_next;

  logic hitHot;
  logic hitHdr;
  logic hitCtrl;
  logic hitVec;
  logic [31:0] merged;
  logic [31:0] ctrlMerged;
  logic [31:0] vecMerged;
  logic [31:0] hdrWord;
  logic [31:0] ctrlWord;

  // Decode of the merged write; role gates which port owns what
  always_comb begin
    hitHot = isUpstream && (wr.addr == acs_regs_pkg::HOT_RESET_OFFSET);
    hitHdr = !isUpstream && (wr.addr == acs_regs_pkg::CAP_HEADER_OFFSET);
    hitCtrl = !isUpstream && (wr.addr == acs_regs_pkg::CAP_CTRL_OFFSET);
    hitVec = !isUpstream && (wr.addr == acs_regs_pkg::EGRESS_VEC_OFFSET);
  end

  // ***************************************************************
  // Write path
  // ***************************************************************
  always_comb begin
    hotResetBlock_next = hotResetBlock_reg;
    nextPtr_next = nextPtr_reg;
    ctrl_next = ctrl_reg;
    egress_next = egress_reg;
    merged = mergeBytes(32'h0000_0000, wr.wrData, wr.byteEn);
    // Merge into the stored word first; a call result cannot be sliced
    ctrlMerged = mergeBytes({9'h000, ctrl_reg, 16'h0000}, wr.wrData,
                            wr.byteEn);
    vecMerged = mergeBytes({16'h0000, egress_reg}, wr.wrData, wr.byteEn);
    if (wr.wrEn) begin
      if (hitHot && wr.byteEn[0]) begin
        hotResetBlock_next = merged[0];
      end
      if (hitHdr && loadEn) begin
        nextPtr_next = wr.wrData[acs_regs_pkg::NEXT_PTR_LSB +: 12];
      end
      if (hitCtrl) begin
        ctrl_next = ctrlMerged[acs_regs_pkg::CTRL_LSB +: 7];
      end
      if (hitVec) begin
        egress_next = vecMerged[15:0];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hotResetBlock_reg <= acs_regs_pkg::HOT_RESET_BLOCK_RESET;
      nextPtr_reg <= acs_regs_pkg::NEXT_PTR_RESET;
      ctrl_reg <= acs_regs_pkg::CTRL_RESET;
      egress_reg <= acs_regs_pkg::EGRESS_VEC_RESET;
    end else begin
      hotResetBlock_reg <= hotResetBlock_next;
      nextPtr_reg <= nextPtr_next;
      ctrl_reg <= ctrl_next;
      egress_reg <= egress_next;
    end
  end

  // ***************************************************************
  // Read path
  // ***************************************************************
  always_comb begin
    hdrWord = {nextPtr_reg, acs_regs_pkg::CAP_VERSION,
               acs_regs_pkg::EXT_CAP_ID};
    ctrlWord = {9'h000, ctrl_reg, acs_regs_pkg::EGRESS_VEC_SIZE, 1'b0,
                acs_regs_pkg::CAP_SUPPORT};
    rdData_next = 32'h0000_0000;
    rdHit_next = 1'b0;
    if (cfgRdEn) begin
      // reserved bits and unmapped reads give zero
      case (cfgAddr)
        acs_regs_pkg::HOT_RESET_OFFSET: begin
          rdHit_next = isUpstream;
          rdData_next = isUpstream ? {31'h0000_0000, hotResetBlock_reg}
                                   : 32'h0000_0000;
        end
        acs_regs_pkg::CAP_HEADER_OFFSET: begin
          rdHit_next = !isUpstream;
          rdData_next = isUpstream ? 32'h0000_0000 : hdrWord;
        end
        acs_regs_pkg::CAP_CTRL_OFFSET: begin
          rdHit_next = !isUpstream;
          rdData_next = isUpstream ? 32'h0000_0000 : ctrlWord;
        end
        acs_regs_pkg::EGRESS_VEC_OFFSET: begin
          rdHit_next = !isUpstream;
          rdData_next = isUpstream ? 32'h0000_0000
                                   : {16'h0000, egress_reg};
        end
        default: begin
          rdHit_next = 1'b0;
          rdData_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_reg <= 32'h0000_0000;
      rdHit_reg <= 1'b0;
    end else begin
      rdData_reg <= rdData_next;
      rdHit_reg <= rdHit_next;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign cfgRdData = rdData_reg;
  assign cfgRdHit = rdHit_reg;
  // Controls forced off on the wrong port role so stale state is inert
  assign downstreamHotResetBlock = hotResetBlock_reg && isUpstream;
  assign sourceValidEn = ctrl_reg[0] && !isUpstream;
  assign transBlockEn = ctrl_reg[1] && !isUpstream;
  assign reqRedirectEn = ctrl_reg[2] && !isUpstream;
  assign cplRedirectEn = ctrl_reg[3] && !isUpstream;
  assign upstreamFwdEn = ctrl_reg[4] && !isUpstream;
  assign egressCtrlEn = ctrl_reg[5] && !isUpstream;
  assign directTransEn = ctrl_reg[6] && !isUpstream;
  assign egressBlockVec = isUpstream ? 16'h0000 : egress_reg;

endmodule : switch_acs_hot_reset_regs

/* File: sim/acs_regs_asserts.sv */
`timescale 1ns/10ps
module acs_regs_asserts (
  // Clock, reset, role
  input wire logic clk,
  input wire logic arst_n,
  input wire logic isUpstream,
  // Register access
  input wire logic cfgWrEn,
  input wire logic cfgRdEn,
  input wire logic [11:0] cfgAddr,
  input wire logic [31:0] cfgWrData,
  input wire logic [3:0] cfgByteEn,
  input wire logic loadEn,
  input wire logic [31:0] cfgRdData,
  input wire logic cfgRdHit,
  // Controls
  input wire logic downstreamHotResetBlock,
  input wire logic sourceValidEn,
  input wire logic egressCtrlEn,
  input wire logic directTransEn,
  input wire logic [15:0] egressBlockVec
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_dsRd(a);
    cfgRdEn && cfgAddr == a && !isUpstream;
  endsequence
  property p_idle; !cfgRdEn |=> !cfgRdHit && cfgRdData == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
  property p_hotGate; !isUpstream |-> !downstreamHotResetBlock; endproperty
  a_hotGate: assert property (p_hotGate) else $error("hot block on down");
  property p_dsGate;
    isUpstream |-> egressBlockVec == 16'h0 && !sourceValidEn && !directTransEn;
  endproperty
  a_dsGate: assert property (p_dsGate) else $error("controls on up");
  property p_hdr; s_dsRd(12'h520) |=> cfgRdHit && cfgRdData[19:0] == 20'h1000d;
  endproperty
  a_hdr: assert property (p_hdr) else $error("header id");
  property p_ctrl;
    s_dsRd(12'h524) |=> cfgRdData[15:0] == 16'h107f && cfgRdData[31:23] == 9'h0
      && cfgRdData[22] == $past(directTransEn)
      && cfgRdData[21] == $past(egressCtrlEn)
      && cfgRdData[16] == $past(sourceValidEn);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("cap word");
  property p_vecWr;
    cfgWrEn && cfgAddr == 12'h528 && cfgByteEn == 4'hf && !loadEn && !isUpstream
      |=> egressBlockVec == $past(cfgWrData[15:0]);
  endproperty
  a_vecWr: assert property (p_vecWr) else $error("vector write");
  property p_hotWr;
    cfgWrEn && cfgAddr == 12'h34c && cfgByteEn[0] && !loadEn && isUpstream
      |=> downstreamHotResetBlock == $past(cfgWrData[0]);
  endproperty
  a_hotWr: assert property (p_hotWr) else $error("hot write");
  property p_unmap;
    cfgRdEn && !(cfgAddr inside {12'h34c, 12'h520, 12'h524, 12'h528})
      |=> !cfgRdHit && cfgRdData == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped hit");
endmodule : acs_regs_asserts
bind switch_acs_hot_reset_regs acs_regs_asserts chk (.*);

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk = 0, arst_n = 0, isUpstream = 0, cfgWrEn = 0, cfgRdEn = 0;
  logic loadEn = 0, cfgRdHit, downstreamHotResetBlock, sourceValidEn;
  logic transBlockEn, reqRedirectEn, cplRedirectEn, upstreamFwdEn;
  logic egressCtrlEn, directTransEn;
  logic [11:0] cfgAddr = 12'h0;
  logic [31:0] cfgWrData = 32'h0, loadData = 32'h0, cfgRdData;
  logic [3:0] cfgByteEn = 4'h0;
  logic [15:0] egressBlockVec;
  logic [6:0] ctrl;
  acs_regs_pkg::load_sel_t loadSel = acs_regs_pkg::LOAD_HOT_RESET;
  int n_fail = 0, compares = 0, i;
  assign ctrl = {directTransEn, egressCtrlEn, upstreamFwdEn, cplRedirectEn,
    reqRedirectEn, transBlockEn, sourceValidEn};
  switch_acs_hot_reset_regs DUT (.*);
  always #2.5 clk = ~clk;
  // ****************
  // Access tasks
  // ****************
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task rs(input logic up);
    arst_n = 0;
    isUpstream = up;
    repeat (8) @(posedge clk);
    #1 arst_n = 1;
  endtask : rs
  // Spare edge after each access keeps strobes from toggling in one step
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
    cfgAddr = a;
    cfgWrData = d;
    cfgByteEn = b;
    cfgWrEn = 1;
    @(posedge clk);
    #1 cfgWrEn = 0;
    @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] e, input logic h);
    cfgAddr = a;
    cfgRdEn = 1;
    @(posedge clk);
    #1 cfgRdEn = 0;
    chk(cfgRdData, e);
    chk({31'h0, cfgRdHit}, {31'h0, h});
    @(posedge clk);
    #1;
  endtask : rd
  task ld(input acs_regs_pkg::load_sel_t s, input logic [31:0] d);
    loadSel = s;
    loadData = d;
    loadEn = 1;
    @(posedge clk);
    #1 loadEn = 0;
    cfgWrEn = 0;
    @(posedge clk);
    #1;
  endtask : ld
  task final_report;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // ****************
  // Tests
  // ****************
  initial begin
    rs(0);
    rd(12'h520, 32'h2701000d, 1);
    rd(12'h524, 32'h0000107f, 1);
    rd(12'h528, 32'h0, 1);
    rd(12'h34c, 32'h0, 0);
    wr(12'h34c, '1, 4'hf);
    chk({31'h0, downstreamHotResetBlock}, 32'h0);
    rd(12'h100, 32'h0, 0);
    $display("test reset done");
    for (i = 0; i < 7; i++) begin
      wr(12'h524, 32'hffff | (32'h1 << (16 + i)), 4'hf);
      chk({25'h0, ctrl}, 32'h1 << i);
      rd(12'h524, (32'h1 << (16 + i)) | 32'h107f, 1);
    end
    wr(12'h524, '1, 4'hf);
    rd(12'h524, 32'h007f107f, 1);
    wr(12'h524, 32'h0, 4'h4);
    rd(12'h524, 32'h0000107f, 1);
    wr(12'h520, 32'h0, 4'hf);
    rd(12'h520, 32'h2701000d, 1);
    wr(12'h528, '1, 4'hf);
    rd(12'h528, 32'h0000ffff, 1);
    wr(12'h528, 32'h5a5a, 4'h2);
    chk({16'h0, egressBlockVec}, 32'h5aff);
    $display("test control done");
    ld(acs_regs_pkg::LOAD_NEXT_PTR, 32'h3000_0000);
    rd(12'h520, 32'h3001000d, 1);
    cfgAddr = 12'h528;
    cfgWrData = 32'h11;
    cfgWrEn = 1;
    ld(acs_regs_pkg::LOAD_EGRESS, 32'hc3);
    chk({16'h0, egressBlockVec}, 32'hc3);
    ld(acs_regs_pkg::LOAD_CTRL, 32'h0050_0000);
    chk({25'h0, ctrl}, 32'h50);
    $display("test preload done");
    rs(1);
    rd(12'h34c, 32'h0, 1);
    wr(12'h34c, '1, 4'hf);
    chk({31'h0, downstreamHotResetBlock}, 32'h1);
    rd(12'h34c, 32'h1, 1);
    rd(12'h520, 32'h0, 0);
    wr(12'h528, '1, 4'hf);
    chk({16'h0, egressBlockVec}, 32'h0);
    ld(acs_regs_pkg::LOAD_HOT_RESET, 32'h0);
    chk({31'h0, downstreamHotResetBlock}, 32'h0);
    $display("test upstream done");
    final_report();
  end
  // Tests need about 0.5 us; sixty times that flags a hang
  initial begin
    #30000;
    n_fail++;
    final_report();
  end
endmodule : tb
